// file: hdl/display_ctrl_pkg.sv
// constants shared by the display controller host port and its refresh timer
// assumes a single 100 MHz clock and an active-high asynchronous reset
package display_ctrl_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // times as printed, in their own units
    localparam int CS_MIN_NS = 6000;
    localparam int READY_LOW_NS = 35000;
    localparam int REFRESH_FRAME_NS = 10000000;
    // chip select least time rounds up, ready low and frame times divide down
    localparam int CS_MIN_CYCLES = (CS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READY_LOW_CYCLES = READY_LOW_NS / CLK_PERIOD_NS;
    localparam int REFRESH_FRAME_CYCLES = REFRESH_FRAME_NS / CLK_PERIOD_NS;
    // readback strobe shape, in cycles
    localparam int OUT_SETUP_CYCLES = 2;
    localparam int OUT_STROBE_CYCLES = 2;

    localparam int MAX_CHARS = 40;
    localparam logic [6:0] SPACE_CODE = 7'h20;
    localparam logic [5:0] INACTIVE_CURSOR = 6'h3f;

    // control word fields
    localparam int CTRL_FLAG_BIT = 7;
    localparam int MODE_MSB = 5;
    localparam int MODE_LSB = 4;
    localparam int LEN_MSB = 3;
    localparam int LEN_LSB = 0;
    localparam logic [1:0] READBACK_LEN_BITS = 2'h3;

    // display length codes
    localparam logic [3:0] LEN16_CODE = 4'h0;
    localparam logic [3:0] LEN24_CODE = 4'h1;
    localparam logic [3:0] LEN32_CODE = 4'h2;
    localparam logic [3:0] LEN40_CODE = 4'h3;

    typedef enum logic [1:0] {
        MODE_LEFT = 2'b00,
        MODE_RIGHT = 2'b01,
        MODE_BLOCK = 2'b10,
        MODE_RAM = 2'b11
    } entry_mode_type;

    localparam entry_mode_type RESET_MODE = MODE_LEFT;
    localparam logic [3:0] RESET_LEN_CODE = LEN40_CODE;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HOLD = 3'b001,
        ST_PROCESS = 3'b010,
        ST_OUT_SETUP = 3'b011,
        ST_OUT_STROBE = 3'b100,
        ST_READY_LOW = 3'b101
    } port_state_type;
endpackage

// file: hdl/refresh_timer.sv
// refresh pulse generator: one-cycle pulse every frame divided by display length
// assumes len_code is always one of the valid length codes
`timescale 1ns/1ps
module refresh_timer #(
    parameter int FRAME_CYCLES = display_ctrl_pkg::REFRESH_FRAME_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] len_code,
    output logic refresh
);
    // one constant per length, so no divider is built
    function automatic logic [19:0] period_of(input logic [3:0] code);
        unique case (code)
            display_ctrl_pkg::LEN16_CODE: period_of = 20'(FRAME_CYCLES / 16);
            display_ctrl_pkg::LEN24_CODE: period_of = 20'(FRAME_CYCLES / 24);
            display_ctrl_pkg::LEN32_CODE: period_of = 20'(FRAME_CYCLES / 32);
            default: period_of = 20'(FRAME_CYCLES / 40);
        endcase
    endfunction

    logic [19:0] count;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count <= 20'h00000;
            refresh <= 1'b0;
        end else if (count >= period_of(len_code) - 20'h00001) begin
            count <= 20'h00000; // [R9]
            refresh <= 1'b1;
        end else begin
            count <= count + 20'h00001;
            refresh <= 1'b0;
        end
    end

    refresh_period_a: assert property (@(posedge ref_clk) disable iff (rst) // [R9]
        $rose(refresh) |-> ##1 (!refresh && count == 20'h00001))
        else $error("refresh pulse longer than one cycle");
endmodule

// file: hdl/display_ctrl_host_readback.sv
// host word port of the alphanumeric display controller, with readback and refresh
// assumes host inputs are synchronous to ref_clk and the host keeps its handshake
`timescale 1ns/1ps
// Function
// R1: a control word with bit 7 and bits 3..2 high starts a readback.
// R2: readback sends status, then cursor address, then stored characters.
// R3: status word is the control word layout without its top two bits.
// R4: cursor address counts from zero at the leftmost position.
// R5: expanded left entry reports cursor 63 when this line is not active.
// R6: number of characters returned equals the configured display length.
// R7: first character returned is the leftmost, then positions to the right.
// R8: host captures each output word on the rising edge of the strobe.
// R9: refresh pulses every ten milliseconds divided by display length.
// R10: blank left open displays normally; a blank pulse dims the display.
// R11: host holds chip select low until the device drives ready low.
// R12: host loads no new word while its interface is busy.
// R13: in RAM entry the host also latches the six-bit RAM address.
// R14: default is forty-character left entry; a reset-time control word overrides.
// R15: control bits 5..4 pick entry mode, 3..0 length, bit 6 ignored.
// R16: bit 7 high marks a control word, low marks a character code.
// R17: chip select low at least 6 us; ready then low for 35 us.
// R18: each readback word is stable before its strobe rises, one strobe per word.
module display_ctrl_host_readback #(
    parameter int FRAME_CYCLES = display_ctrl_pkg::REFRESH_FRAME_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] data_in,
    input wire logic [5:0] ram_addr,
    input wire logic chip_select_n,
    input wire logic expand_n,
    input wire logic line_active,
    input wire logic blank_n,
    output logic ready,
    output logic [7:0] data_out,
    output logic data_valid,
    output logic refresh,
    output logic display_on,
    output logic [1:0] entry_mode,
    output logic [3:0] len_code
);
    function automatic logic [5:0] len_of(input logic [3:0] code);
        unique case (code)
            display_ctrl_pkg::LEN16_CODE: len_of = 6'h10;
            display_ctrl_pkg::LEN24_CODE: len_of = 6'h18;
            display_ctrl_pkg::LEN32_CODE: len_of = 6'h20;
            display_ctrl_pkg::LEN40_CODE: len_of = 6'h28;
            default: len_of = 6'h00;
        endcase
    endfunction

    function automatic logic is_readback(input logic [7:0] w);
        is_readback = w[display_ctrl_pkg::CTRL_FLAG_BIT]
            && w[3:2] == display_ctrl_pkg::READBACK_LEN_BITS;
    endfunction

    display_ctrl_pkg::port_state_type state;
    logic [11:0] timer;
    logic [7:0] word;
    logic [5:0] cursor;
    logic [5:0] out_index;
    logic [5:0] length;
    logic expanded;
    logic init_pending;
    logic [6:0] chars [display_ctrl_pkg::MAX_CHARS];
    logic [7:0] next_word_out;
    logic [5:0] report_cursor;
    logic do_char;
    logic do_clear;

    assign length = len_of(len_code);
    assign do_char = state == display_ctrl_pkg::ST_PROCESS && !word[display_ctrl_pkg::CTRL_FLAG_BIT]; // [R16]
    assign do_clear = state == display_ctrl_pkg::ST_PROCESS && word[display_ctrl_pkg::CTRL_FLAG_BIT]
        && !is_readback(word) && len_of(word[3:0]) != 6'h00
        && word[5:4] != display_ctrl_pkg::MODE_RAM;

    // handshake sequencer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= display_ctrl_pkg::ST_IDLE;
            timer <= 12'h000;
            word <= 8'h00;
            out_index <= 6'h00;
        end else begin
            unique case (state)
                display_ctrl_pkg::ST_IDLE: begin
                    timer <= 12'h000;
                    if (!chip_select_n && !init_pending) begin
                        state <= display_ctrl_pkg::ST_HOLD;
                    end
                end
                display_ctrl_pkg::ST_HOLD: begin
                    // a select shorter than the minimum is dropped
                    if (chip_select_n) begin
                        state <= display_ctrl_pkg::ST_IDLE;
                    end else if (timer == 12'(display_ctrl_pkg::CS_MIN_CYCLES - 2)) begin
                        word <= data_in; // [R17]
                        timer <= 12'h000;
                        state <= display_ctrl_pkg::ST_PROCESS;
                    end else begin
                        timer <= timer + 12'h001;
                    end
                end
                display_ctrl_pkg::ST_PROCESS: begin
                    out_index <= 6'h00;
                    timer <= 12'h000;
                    if (is_readback(word)) begin
                        state <= display_ctrl_pkg::ST_OUT_SETUP; // [R1]
                    end else begin
                        state <= display_ctrl_pkg::ST_READY_LOW;
                    end
                end
                display_ctrl_pkg::ST_OUT_SETUP: begin
                    if (timer == 12'(display_ctrl_pkg::OUT_SETUP_CYCLES - 1)) begin
                        timer <= 12'h000;
                        state <= display_ctrl_pkg::ST_OUT_STROBE; // [R18]
                    end else begin
                        timer <= timer + 12'h001;
                    end
                end
                display_ctrl_pkg::ST_OUT_STROBE: begin
                    if (timer == 12'(display_ctrl_pkg::OUT_STROBE_CYCLES - 1)) begin
                        timer <= 12'h000;
                        out_index <= out_index + 6'h01;
                        // two header words then one per position
                        if (out_index == length + 6'h01) begin
                            state <= display_ctrl_pkg::ST_READY_LOW; // [R6]
                        end else begin
                            state <= display_ctrl_pkg::ST_OUT_SETUP;
                        end
                    end else begin
                        timer <= timer + 12'h001;
                    end
                end
                display_ctrl_pkg::ST_READY_LOW: begin
                    if (timer == 12'(display_ctrl_pkg::READY_LOW_CYCLES - 1)) begin
                        state <= display_ctrl_pkg::ST_IDLE; // [R17]
                    end else begin
                        timer <= timer + 12'h001;
                    end
                end
                default: state <= display_ctrl_pkg::ST_IDLE;
            endcase
        end
    end

    // ready is low only for the fixed busy window after a word
    assign ready = state != display_ctrl_pkg::ST_READY_LOW; // [R11]

    // configuration; power-up default, replaced by a strap word seen at release
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            entry_mode <= display_ctrl_pkg::RESET_MODE; // [R14]
            len_code <= display_ctrl_pkg::RESET_LEN_CODE;
            expanded <= 1'b0;
            init_pending <= 1'b1;
        end else if (init_pending) begin
            init_pending <= 1'b0;
            expanded <= !expand_n;
            if (data_in[display_ctrl_pkg::CTRL_FLAG_BIT] && len_of(data_in[3:0]) != 6'h00) begin
                entry_mode <= data_in[display_ctrl_pkg::MODE_MSB:display_ctrl_pkg::MODE_LSB]; // [R14]
                len_code <= data_in[display_ctrl_pkg::LEN_MSB:display_ctrl_pkg::LEN_LSB];
            end
        end else if (state == display_ctrl_pkg::ST_PROCESS && word[display_ctrl_pkg::CTRL_FLAG_BIT]
                     && !is_readback(word) && len_of(word[3:0]) != 6'h00) begin
            // bit 6 plays no part
            entry_mode <= word[display_ctrl_pkg::MODE_MSB:display_ctrl_pkg::MODE_LSB]; // [R15]
            len_code <= word[display_ctrl_pkg::LEN_MSB:display_ctrl_pkg::LEN_LSB];
        end
    end

    // cursor tracks the next entry position
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cursor <= 6'h00;
        end else if (init_pending || do_clear) begin
            cursor <= 6'h00;
        end else if (do_char) begin
            unique case (entry_mode)
                display_ctrl_pkg::MODE_LEFT: if (cursor < length) cursor <= cursor + 6'h01;
                display_ctrl_pkg::MODE_RIGHT: cursor <= length;
                display_ctrl_pkg::MODE_BLOCK: cursor <= (cursor + 6'h01 >= length) ? 6'h00 : cursor + 6'h01;
                display_ctrl_pkg::MODE_RAM: if (ram_addr < length) cursor <= ram_addr + 6'h01; // [R13]
            endcase
        end
    end

    // character store, one generated cell per position
    for (genvar i = 0; i < display_ctrl_pkg::MAX_CHARS; i++) begin : g_cell
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                chars[i] <= display_ctrl_pkg::SPACE_CODE;
            end else if (init_pending || do_clear) begin
                chars[i] <= display_ctrl_pkg::SPACE_CODE;
            end else if (do_char) begin
                unique case (entry_mode)
                    display_ctrl_pkg::MODE_RIGHT: begin
                        // shift left, new code enters at the rightmost position
                        if (6'(i) + 6'h01 == length) begin
                            chars[i] <= word[6:0];
                        end else if (6'(i) + 6'h01 < length) begin
                            chars[i] <= chars[(i + 1) % display_ctrl_pkg::MAX_CHARS];
                        end
                    end
                    display_ctrl_pkg::MODE_RAM: if (ram_addr == 6'(i)) chars[i] <= word[6:0];
                    default: if (cursor == 6'(i) && cursor < length) chars[i] <= word[6:0];
                endcase
            end
        end
    end

    // cursor as reported, 63 flags an inactive line in expanded left entry
    assign report_cursor = (expanded && entry_mode == display_ctrl_pkg::MODE_LEFT && !line_active)
        ? display_ctrl_pkg::INACTIVE_CURSOR : cursor; // [R5] [R4]

    always_comb begin
        if (out_index == 6'h00) begin
            next_word_out = {2'b00, entry_mode, len_code}; // [R3]
        end else if (out_index == 6'h01) begin
            next_word_out = {2'b00, report_cursor};
        end else begin
            // index 2 is position 0, the leftmost
            next_word_out = {1'b0, chars[(out_index - 6'h02) % 6'(display_ctrl_pkg::MAX_CHARS)]}; // [R7]
        end
    end

    // output word set at setup start, strobe rises later so the host latch is safe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_out <= 8'h00;
            data_valid <= 1'b0;
        end else begin
            if (state == display_ctrl_pkg::ST_OUT_SETUP && timer == 12'h000) begin
                data_out <= next_word_out; // [R2]
            end
            data_valid <= state == display_ctrl_pkg::ST_OUT_SETUP
                && timer == 12'(display_ctrl_pkg::OUT_SETUP_CYCLES - 1)
                || state == display_ctrl_pkg::ST_OUT_STROBE
                && timer != 12'(display_ctrl_pkg::OUT_STROBE_CYCLES - 1); // [R8]
        end
    end

    // open blank input is pulled high, so the display stays lit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            display_on <= 1'b0;
        end else begin
            display_on <= blank_n; // [R10]
        end
    end

    refresh_timer #(
        .FRAME_CYCLES(FRAME_CYCLES)
    ) u_refresh (
        .ref_clk(ref_clk),
        .rst(rst),
        .len_code(len_code),
        .refresh(refresh)
    );

    // helper: strobes counted within one readback
    logic [6:0] strobes;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strobes <= 7'h00;
        end else if (state == display_ctrl_pkg::ST_PROCESS) begin
            strobes <= 7'h00;
        end else if (data_valid && !$past(data_valid)) begin
            strobes <= strobes + 7'h01;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    readback_start_a: assert property (state == display_ctrl_pkg::ST_PROCESS && is_readback(word) // [R1]
        |=> state == display_ctrl_pkg::ST_OUT_SETUP)
        else $error("readback command did not start output");
    word_count_a: assert property ($fell(ready) && $past(state) == display_ctrl_pkg::ST_OUT_STROBE // [R6]
        |-> strobes == 7'(length) + 7'h02)
        else $error("wrong number of readback words");
    status_word_a: assert property ($rose(data_valid) && strobes == 7'h00 // [R3]
        |-> data_out == {2'b00, entry_mode, len_code})
        else $error("status word mismatch");
    first_char_a: assert property ($rose(data_valid) && strobes == 7'h02 // [R7]
        |-> data_out == {1'b0, chars[0]})
        else $error("first character is not the leftmost");
    data_stable_a: assert property (data_valid |-> $stable(data_out)) // [R18]
        else $error("output word changed while strobe high");
    setup_before_a: assert property ($rose(data_valid) |-> $past(data_out) == data_out) // [R8]
        else $error("word not stable before strobe edge");
    // judged on the word actually strobed out, not on the mux feeding it
    inactive_line_a: assert property ($rose(data_valid) && strobes == 7'h01 && expanded // [R5]
        && entry_mode == display_ctrl_pkg::MODE_LEFT && !line_active
        |-> data_out == 8'h3f)
        else $error("inactive line cursor not 63");
    ready_low_a: assert property ($fell(ready) |-> !ready [*8] ##1 state == display_ctrl_pkg::ST_READY_LOW) // [R17]
        else $error("ready low window too short");
    blank_follow_a: assert property (!blank_n |=> !display_on) // [R10]
        else $error("blank did not darken display");

    readback_done_c: cover property ($fell(ready) && $past(state) == display_ctrl_pkg::ST_OUT_STROBE);
    char_write_c: cover property (do_char && entry_mode == display_ctrl_pkg::MODE_RIGHT);
    mode_change_c: cover property (do_clear);
    short_select_c: cover property (state == display_ctrl_pkg::ST_HOLD && chip_select_n);
endmodule

// file: bench/host_model.sv
// host side of the word port: a latched host that offers one word under select and catches readback words
// assumes ref_clk is the controller clock and that one bench process calls the tasks
`timescale 1ns/1ps
module host_model (
    input wire logic ref_clk,
    input wire logic ready,
    input wire logic [7:0] data_out,
    input wire logic data_valid,
    output logic [7:0] data_in,
    output logic [5:0] ram_addr,
    output logic chip_select_n
);
    logic [7:0] captured[$];
    logic valid_prev;

    initial begin
        data_in = 8'h00;
        ram_addr = 6'h00;
        chip_select_n = 1'b1;
        valid_prev = 1'b0;
    end

    // words are taken only on the strobe's rising edge
    always @(posedge ref_clk) begin
        if (data_valid === 1'b1 && valid_prev !== 1'b1) begin
            captured.push_back(data_out);
        end
        valid_prev <= data_valid;
    end

    task automatic set_bus(input logic [7:0] w);
        data_in = w; // word offered without select, during reset or just after release
    endtask

    // select dropped before the minimum low time; the word must be ignored
    task automatic short_select(input logic [7:0] w, input int cycles);
        data_in = w;
        chip_select_n = 1'b0;
        repeat (cycles) @(negedge ref_clk);
        chip_select_n = 1'b1;
        data_in = ~w;
    endtask

    // extra holds select past ready low, as a slow host would
    task automatic send_word(input logic [7:0] w, input logic [5:0] a, input int extra, output int low_cycles);
        int n;
        n = 0;
        captured.delete();
        while (ready !== 1'b1 && n < 5000) begin // no new word while busy
            @(negedge ref_clk);
            n++;
        end
        data_in = w;
        ram_addr = a; // address latched beside the word
        chip_select_n = 1'b0;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (ready !== 1'b0 && n < 6000); // select held until ready low
        low_cycles = 1;
        for (n = 0; n < 5000; n++) begin
            if (n == extra) begin
                chip_select_n = 1'b1;
                // a released latch shows no stale word
                data_in = ~w;
                ram_addr = ~a;
            end
            @(negedge ref_clk);
            if (ready !== 1'b0) begin
                break;
            end
            low_cycles++;
        end
    endtask
endmodule

// file: bench/display_ctrl_host_readback_tb_top.sv
// self-checking bench for the display controller host port, readback and refresh timer
// assumes the host model drives the word port; frame count shortened to keep the run short
`timescale 1ns/1ps
module display_ctrl_host_readback_tb_top;
    localparam int FRAME = 4000;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic expand_n = 1'b1;
    logic line_active = 1'b1;
    logic blank_n = 1'b1;
    logic [7:0] data_in;
    logic [5:0] ram_addr;
    logic chip_select_n;
    logic ready;
    logic [7:0] data_out;
    logic data_valid;
    logic refresh;
    logic display_on;
    logic [1:0] entry_mode;
    logic [3:0] len_code;
    int n_mismatch = 0;
    int checks = 0;
    logic [7:0] mode_words[4] = '{8'h80, 8'hd1, 8'ha2, 8'hb3};

    always #5 ref_clk = ~ref_clk;

    display_ctrl_host_readback #(.FRAME_CYCLES(FRAME)) i_display_ctrl_host_readback (
        .ref_clk(ref_clk), .rst(rst), .data_in(data_in), .ram_addr(ram_addr),
        .chip_select_n(chip_select_n), .expand_n(expand_n), .line_active(line_active),
        .blank_n(blank_n), .ready(ready), .data_out(data_out), .data_valid(data_valid),
        .refresh(refresh), .display_on(display_on), .entry_mode(entry_mode), .len_code(len_code)
    );

    host_model i_host_model (
        .ref_clk(ref_clk), .ready(ready), .data_out(data_out), .data_valid(data_valid),
        .data_in(data_in), .ram_addr(ram_addr), .chip_select_n(chip_select_n)
    );

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic logic [15:0] ch(input int i);
        return {8'h00, i_host_model.captured[i + 2]};
    endfunction

    task automatic do_reset(input logic [7:0] strap, input logic exp_n);
        @(negedge ref_clk);
        rst = 1'b1;
        expand_n = exp_n;
        i_host_model.set_bus(strap);
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        i_host_model.set_bus(~strap);
    endtask

    task automatic put(input logic [7:0] w, input logic [5:0] a);
        int lc;
        i_host_model.send_word(w, a, 0, lc);
        check("ready low span", 16'(lc), 16'(display_ctrl_pkg::READY_LOW_CYCLES));
    endtask

    task automatic readback(input logic [7:0] cmd, input logic [7:0] status, input logic [7:0] cursor, input int len);
        int lc;
        i_host_model.send_word(cmd, 6'h00, 3, lc);
        check("ready low span", 16'(lc), 16'(display_ctrl_pkg::READY_LOW_CYCLES));
        check("word count", 16'(i_host_model.captured.size()), 16'(len + 2));
        check("status word", {8'h00, i_host_model.captured[0]}, {8'h00, status});
        check("cursor word", {8'h00, i_host_model.captured[1]}, {8'h00, cursor});
    endtask

    task automatic refresh_period(output int n);
        n = 0;
        while (refresh !== 1'b1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (refresh !== 1'b1 && n < 400);
    endtask

    task automatic t_defaults();
        do_reset(8'h00, 1'b1);
        check("mode after reset", {14'h0, entry_mode}, 16'h0000);
        check("length after reset", {12'h0, len_code}, 16'h0003);
        check("ready after reset", {15'h0, ready}, 16'h0001);
    endtask

    task automatic t_left_readback();
        put(8'h41, 6'h00);
        put(8'h42, 6'h00);
        put(8'h43, 6'h00);
        readback(8'h8c, 8'h03, 8'h03, 40);
        for (int i = 0; i < 40; i++) begin
            check("left char", ch(i), (i < 3) ? 16'(8'h41 + i) : 16'h0020);
        end
        // all don't-care bits set must still read back, not reconfigure
        readback(8'hff, 8'h03, 8'h03, 40);
        check("mode kept", {14'h0, entry_mode}, 16'h0000);
    endtask

    task automatic t_modes();
        int p;
        foreach (mode_words[k]) begin
            put(mode_words[k], 6'h00);
            check("mode field", {14'h0, entry_mode}, {14'h0, mode_words[k][5:4]});
            check("length field", {12'h0, len_code}, {12'h0, mode_words[k][3:0]});
            refresh_period(p);
            check("refresh period", 16'(p), 16'(FRAME / (16 + 8 * k)));
        end
    endtask

    task automatic t_invalid_and_ram();
        put(8'h87, 6'h00);
        check("bad length ignored", {12'h0, len_code}, 16'h0003);
        check("mode held", {14'h0, entry_mode}, 16'h0003);
        put(8'h51, 6'h2d);
        put(8'h5a, 6'h05);
        readback(8'h8c, 8'h33, 8'h06, 40);
        for (int i = 0; i < 40; i++) begin
            check("ram char", ch(i), (i == 5) ? 16'h005a : 16'h0020);
        end
    endtask

    task automatic t_blank();
        blank_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        check("dimmed", {15'h0, display_on}, 16'h0000);
        blank_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        check("open blank", {15'h0, display_on}, 16'h0001);
    endtask

    // one sample short of the minimum select, then right entry shifting
    task automatic t_right_short();
        i_host_model.short_select(8'h80, 599);
        repeat (4) @(negedge ref_clk);
        check("short select ready", {15'h0, ready}, 16'h0001);
        check("short select length", {12'h0, len_code}, 16'h0003);
        put(8'h91, 6'h00);
        put(8'h41, 6'h00);
        put(8'h42, 6'h00);
        readback(8'h8c, 8'h11, 8'h18, 24);
        for (int i = 0; i < 24; i++) begin
            check("right char", ch(i), (i < 22) ? 16'h0020 : 16'(8'h41 + i - 22));
        end
    endtask

    task automatic t_straps();
        do_reset(8'h92, 1'b1);
        check("strap mode", {14'h0, entry_mode}, 16'h0001);
        check("strap length", {12'h0, len_code}, 16'h0002);
        do_reset(8'h00, 1'b0);
        line_active = 1'b0;
        readback(8'h8c, 8'h03, 8'h3f, 40);
        line_active = 1'b1;
        readback(8'h8c, 8'h03, 8'h00, 40);
    endtask

    initial begin
        repeat (95000) @(posedge ref_clk);
        n_mismatch++;
        end_sim();
    end

    initial begin
        t_defaults();
        t_left_readback();
        t_modes();
        t_invalid_and_ram();
        t_blank();
        t_right_short();
        t_straps();
        end_sim();
    end
endmodule
